// [verilog/tht_defines.vh]
// Constants for the thermal throttle controller: register offsets,
// field positions, reset values and timing counts.
// Assumes a single 250 MHz core clock and an AHB-Lite register bus.
//
// Summary of operation
// - Catastrophic trip halts execution until reset; it has no enable.
// - Catastrophic path has no register, flag or capability bit for software.
// - Duty-cycle method gates core clock on and off when sensor trips.
// - Gating uses internal stop-clock only, never the external clock-stop pin.
// - Duty cycle sets fraction of clock pulses passed, not waveform shape.
// - Duty-cycle enable is misc enable bit 3, cleared at reset.
// - Capability word reports duty-cycle support at EDX bit 29.
// - Capability word reports frequency/voltage support at ECX bit 8.
// - Frequency/voltage method lowers frequency and voltage, no clock gating.
// - Both methods are triggered by the same throttle sensor trip.
// - Early parts: freq/voltage method when select bit 16 and bit 3 set.
// - Early parts: duty-cycle method when bit 3 set and select clear.
// - Method select resets cleared; nothing relies on another value.
// - Later parts: freq/voltage method enabled by misc enable bit 13.
// - On trigger, move to target operating point in control bits 15:0.
// - Duty-cycle engaged: performance request may start at once.
// - Freq/voltage engaged: performance request held until disengaged.
// - Throttle stays engaged at least about 1 ms and while still hot.
`ifndef THT_DEFINES_VH
`define THT_DEFINES_VH

// Register byte offsets
`define THT_MISC_EN_OFS 8'h00
`define THT_CTL_OFS 8'h04
`define THT_PERF_OFS 8'h08
`define THT_CAPA_OFS 8'h0c
`define THT_CAPB_OFS 8'h10
`define THT_STAT_OFS 8'h14

// Field positions
`define THT_DUTY_EN_BIT 3
`define THT_FV_EN_BIT 13
`define THT_SEL_BIT 16
`define THT_CAP_DUTY_BIT 29
`define THT_CAP_FV_BIT 8

// Reset values
`define THT_MISC_EN_RST 32'h0000_0000
`define THT_CTL_RST 32'h0000_0000
`define THT_PERF_RST 16'h0000

// Timing: least engaged time and clock rate
`define THT_HOLD_NS 1000000
`define THT_CLK_NS 4
`define THT_HOLD_CYC ((`THT_HOLD_NS + `THT_CLK_NS - 1) / `THT_CLK_NS)

`endif

// [verilog/tht_gate_gen.v]
// Stop-clock pattern generator for duty-cycle throttling.
// Assumes the core clock; emits a one-bit clock-allow level.
`timescale 1ns/1ns
module tht_gate_gen #(
   parameter PERIOD = 8,
   parameter ON_CNT = 4
) (
   input wire core_clk,
   input wire rst_n,
   input wire run,
   output reg allow_q
);
   reg [7:0] cnt_q;

   // Free-running phase counter, restarted whenever throttling stops
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 8'h00;
         allow_q <= 1'b1;
      end else if (!run) begin
         cnt_q <= 8'h00;
         allow_q <= 1'b1;
      end else begin
         if (cnt_q == PERIOD[7:0] - 8'h01)
            cnt_q <= 8'h00;
         else
            cnt_q <= cnt_q + 8'h01;
         // Pulses pass only for the first ON_CNT slots; shape untouched
         allow_q <= (cnt_q < ON_CNT[7:0]);
      end
   end
endmodule

// [verilog/tht_ctrl.v]
// Thermal throttle controller: sensor sync, method select, hold timer,
// stop-clock gating, operating point target and perf request gating.
// Assumes AHB-Lite with one slave, trip inputs asynchronous to the clock.
`timescale 1ns/1ns
`include "tht_defines.vh"
module tht_ctrl #(
   parameter HOLD_CYC = `THT_HOLD_CYC,
   parameter EARLY_PART = 0,
   parameter GATE_PERIOD = 8,
   parameter GATE_ON = 4
) (
   input wire core_clk,
   input wire rst_n,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   input wire cat_trip,
   input wire therm_trip,
   output reg exec_halt_q,
   output reg core_clk_allow_q,
   output reg fv_active_q,
   output reg [15:0] op_point_q,
   output reg perf_start_q,
   output reg [15:0] perf_target_q
);
   reg cat_s1_q, cat_s2_q, trip_s1_q, trip_s2_q;
   reg [31:0] misc_q;
   reg [31:0] ctl_q;
   reg [15:0] perf_req_q;
   reg perf_pend_q;
   reg engaged_q;
   reg [31:0] hold_q;
   reg [7:0] wr_ofs_q;
   reg wr_pend_q;
   reg duty_mode;
   reg fv_mode;
   wire allow;
   wire wr_perf;
   wire [31:0] cap_a;
   wire [31:0] cap_b;

   // Two-flop synchronisers; only the second stage is used
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cat_s1_q <= 1'b0;
         cat_s2_q <= 1'b0;
         trip_s1_q <= 1'b0;
         trip_s2_q <= 1'b0;
      end else begin
         cat_s1_q <= cat_trip;
         cat_s2_q <= cat_s1_q;
         trip_s1_q <= therm_trip;
         trip_s2_q <= trip_s1_q;
      end
   end

   // Catastrophic halt: sticky until reset, nothing can clear it
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n)
         exec_halt_q <= 1'b0;
      else if (cat_s2_q)
         exec_halt_q <= 1'b1;
   end

   // Method decode; select bit only matters on early parts
   always @* begin
      if (EARLY_PART != 0) begin
         fv_mode = misc_q[`THT_DUTY_EN_BIT] &
                   ctl_q[`THT_SEL_BIT];
         duty_mode = misc_q[`THT_DUTY_EN_BIT] &
                     ~ctl_q[`THT_SEL_BIT];
      end else begin
         fv_mode = misc_q[`THT_FV_EN_BIT];
         // Frequency/voltage wins when firmware enabled both
         duty_mode = misc_q[`THT_DUTY_EN_BIT] &
                     ~misc_q[`THT_FV_EN_BIT];
      end
   end

   // Engagement: one sensor for both methods, held at least HOLD_CYC
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         engaged_q <= 1'b0;
         hold_q <= 32'h0000_0000;
      end else if (trip_s2_q && (duty_mode || fv_mode)) begin
         engaged_q <= 1'b1;
         hold_q <= HOLD_CYC[31:0];
      end else if (hold_q != 32'h0000_0000) begin
         hold_q <= hold_q - 32'h0000_0001;
      end else begin
         // Sensor hysteresis lives in the sensor; low trip means cooled
         engaged_q <= 1'b0;
      end
   end

   // Internal stop-clock pattern; the external stop pin plays no part
   tht_gate_gen #(
      .PERIOD(GATE_PERIOD),
      .ON_CNT(GATE_ON)
   ) u_gate (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .run(engaged_q & duty_mode),
      .allow_q(allow)
   );

   // Clock allow, halt overrides everything
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n)
         core_clk_allow_q <= 1'b1;
      else if (exec_halt_q)
         core_clk_allow_q <= 1'b0;
      else if (engaged_q && duty_mode)
         core_clk_allow_q <= allow;
      else
         core_clk_allow_q <= 1'b1;
   end

   // Operating point: target field while freq/voltage throttle engaged
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         fv_active_q <= 1'b0;
         op_point_q <= `THT_PERF_RST;
      end else begin
         fv_active_q <= engaged_q & fv_mode;
         if (engaged_q && fv_mode)
            op_point_q <= ctl_q[15:0];
         else
            op_point_q <= perf_target_q;
      end
   end

   // AHB-Lite address phase capture; writes complete in the data phase
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_pend_q <= 1'b0;
         wr_ofs_q <= 8'h00;
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wr_pend_q <= 1'b0;
         if (hsel && hready && htrans[1]) begin
            wr_pend_q <= hwrite;
            wr_ofs_q <= haddr[7:0];
            case (haddr[7:0])
               `THT_MISC_EN_OFS: hrdata <= misc_q;
               `THT_CTL_OFS: hrdata <= ctl_q;
               `THT_PERF_OFS: hrdata <= {16'h0000, perf_req_q};
               `THT_CAPA_OFS: hrdata <= cap_a;
               `THT_CAPB_OFS: hrdata <= cap_b;
               `THT_STAT_OFS: hrdata <= {29'h0, perf_pend_q,
                                         fv_active_q, engaged_q};
               default: hrdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Capability words; no bit speaks of the catastrophic path
   assign cap_a = 32'h1 << `THT_CAP_DUTY_BIT;
   assign cap_b = 32'h1 << `THT_CAP_FV_BIT;
   assign wr_perf = wr_pend_q && (wr_ofs_q == `THT_PERF_OFS);

   // Software registers; select resets cleared and is not relied upon
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         misc_q <= `THT_MISC_EN_RST;
         ctl_q <= `THT_CTL_RST;
         perf_req_q <= `THT_PERF_RST;
      end else if (wr_pend_q) begin
         case (wr_ofs_q)
            `THT_MISC_EN_OFS: misc_q <= hwdata;
            `THT_CTL_OFS: ctl_q <= hwdata;
            `THT_PERF_OFS: perf_req_q <= hwdata[15:0];
            default: ;
         endcase
      end
   end

   // Performance request: pass at once unless freq/voltage engaged
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         perf_pend_q <= 1'b0;
         perf_start_q <= 1'b0;
         perf_target_q <= `THT_PERF_RST;
      end else begin
         perf_start_q <= 1'b0;
         if (wr_perf && engaged_q && fv_mode) begin
            perf_pend_q <= 1'b1;
         end else if (wr_perf || (perf_pend_q && !(engaged_q && fv_mode)))
         begin
            // A new write while pending also starts once allowed
            perf_pend_q <= 1'b0;
            perf_start_q <= 1'b1;
            perf_target_q <= wr_perf ? hwdata[15:0] : perf_req_q;
         end
      end
   end
endmodule

// [bench/tht_sensor_model.sv]
// Behavioural on-die temperature sensors for the throttle bench.
// Assumes the bench commands hot and cat levels on the core clock.
`timescale 1ns/1ns
module tht_sensor_model (
   input wire core_clk,
   input wire hot,
   input wire cat,
   output reg therm_trip = 1'b0,
   output reg cat_trip = 1'b0
);
   // Trips follow the commands one edge late; hysteresis is in the command
   always @(posedge core_clk) begin
      therm_trip <= hot;
      cat_trip <= cat;
   end
endmodule

// [bench/tht_ctrl_sva.sv]
// Port checker for the thermal throttle controller.
// Assumes it is bound to tht_ctrl and sees only its ports.
`timescale 1ns/1ns
module tht_ctrl_sva #(
   parameter HOLD_CYC = 20
) (
   input wire core_clk,
   input wire rst_n,
   input wire hreadyout,
   input wire hresp,
   input wire therm_trip,
   input wire cat_trip,
   input wire exec_halt_q,
   input wire core_clk_allow_q,
   input wire fv_active_q,
   input wire perf_start_q
);
   reg [31:0] cool_q;
   // Cycles since the trip was last high; saturates so it never wraps
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n)
         cool_q <= 32'h0;
      else if (therm_trip)
         cool_q <= 32'h0;
      else if (cool_q != 32'hffff_ffff)
         cool_q <= cool_q + 32'h1;
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // A clock gap longer than the off part of the pattern
   sequence s_gap;
      !core_clk_allow_q [*5];
   endsequence
   a_halt_sticky: assert property (exec_halt_q |=> exec_halt_q)
      else $error("halt released without reset");
   a_cat_halts: assert property ($rose(cat_trip) |-> ##[1:4] exec_halt_q)
      else $error("catastrophic trip did not halt");
   a_halt_no_clk: assert property (exec_halt_q |=> !core_clk_allow_q)
      else $error("clock passes while halted");
   a_gate_gap: assert property (s_gap |-> exec_halt_q)
      else $error("clock stopped longer than the pattern allows");
   a_fv_no_gate: assert property (fv_active_q && !exec_halt_q
      |-> core_clk_allow_q)
      else $error("clock gated in frequency mode");
   a_fv_cause: assert property ($rose(fv_active_q) |-> $past(therm_trip, 2))
      else $error("frequency mode without a trip");
   a_hold_min: assert property ($fell(fv_active_q) |-> cool_q >= HOLD_CYC)
      else $error("throttle released too early");
   a_start_pulse: assert property (perf_start_q |=> !perf_start_q)
      else $error("perf start longer than one cycle");
   a_bus_okay: assert property (!hresp && hreadyout)
      else $error("bus response not okay");
endmodule
bind tht_ctrl tht_ctrl_sva #(.HOLD_CYC(HOLD_CYC)) u_sva (.core_clk(core_clk),
   .rst_n(rst_n), .hreadyout(hreadyout), .hresp(hresp),
   .therm_trip(therm_trip), .cat_trip(cat_trip), .exec_halt_q(exec_halt_q),
   .core_clk_allow_q(core_clk_allow_q), .fv_active_q(fv_active_q),
   .perf_start_q(perf_start_q));

// [bench/thermal_throttle_control_test.sv]
// Self-checking bench for the thermal throttle controller.
// Assumes an AHB-Lite master here and a behavioural sensor model.
`timescale 1ns/1ns
module thermal_throttle_control_test;
   localparam HC = 20;
   reg core_clk = 0, rst_n = 0, hsel = 0, hwrite = 0, hot = 0, cat = 0;
   reg [31:0] haddr = 0, hwdata = 0, rdv = 0;
   reg [1:0] htrans = 0;
   reg [2:0] hsize = 3'h2;
   wire [31:0] hrdata;
   wire [15:0] opp, pt;
   wire hreadyout, hresp, cat_trip, therm_trip, halt, allow, fv, ps;
   wire allow_e, fv_e;
   integer miscompares = 0, compares = 0, cyc = 0, n, n2, i;
   // Short hold keeps the run brief; expectations use HC
   tht_ctrl #(.HOLD_CYC(HC)) DUT (.core_clk(core_clk), .rst_n(rst_n),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .cat_trip(cat_trip),
      .therm_trip(therm_trip), .exec_halt_q(halt), .core_clk_allow_q(allow),
      .fv_active_q(fv), .op_point_q(opp), .perf_start_q(ps),
      .perf_target_q(pt));
   // Early-part decode on the same bus and sensors; only its method outputs
   // are compared, so the select bit path is exercised too
   tht_ctrl #(.HOLD_CYC(HC), .EARLY_PART(1)) DUT_E (.core_clk(core_clk),
      .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(), .hreadyout(), .hresp(), .cat_trip(cat_trip),
      .therm_trip(therm_trip), .exec_halt_q(), .core_clk_allow_q(allow_e),
      .fv_active_q(fv_e), .op_point_q(), .perf_start_q(),
      .perf_target_q());
   tht_sensor_model u_sen (.core_clk(core_clk), .hot(hot), .cat(cat),
      .therm_trip(therm_trip), .cat_trip(cat_trip));
   // 250 MHz core clock
   initial forever #2 core_clk = ~core_clk;
   // Hang guard
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         miscompares = miscompares + 1;
         final_report;
      end
   end
   task final_report;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (compares > 0 && miscompares == 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task chk(input string nm, input [31:0] e, input [31:0] s);
      compares = compares + 1;
      if (s !== e) begin
         miscompares = miscompares + 1;
         $display("unexpected %0s expected %h seen %h", nm, e, s);
      end
   endtask
   task wt(input integer c);
      repeat (c) @(posedge core_clk);
   endtask
   // One single transfer; read data taken at the data phase edge
   task bus(input w, input [7:0] a, input [31:0] d);
      hsel <= 1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge core_clk);
      while (hreadyout !== 1'b1) @(posedge core_clk);
      hsel <= 0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge core_clk);
      while (hreadyout !== 1'b1) @(posedge core_clk);
      rdv = hrdata;
   endtask
   // Cycles until the perf start pulse, bounded
   task wt_start;
      n = 0;
      while (ps !== 1'b1 && n < HC * 4) begin
         wt(1);
         n = n + 1;
      end
   endtask
   initial begin
      wt(10);
      rst_n <= 1;
      wt(1);
      bus(0, 8'h00, 0); chk("misc", 0, rdv);
      bus(0, 8'h04, 0); chk("ctl", 0, rdv);
      bus(0, 8'h0c, 0); chk("cap_duty", 1, rdv[29]);
      bus(0, 8'h10, 0); chk("cap_fv", 1, rdv[8]);
      bus(0, 8'h20, 0); chk("unmapped", 0, rdv);
      // No method enabled, so a trip changes nothing
      hot <= 1; wt(30);
      bus(0, 8'h14, 0); chk("stat_off", 0, rdv);
      hot <= 0; wt(30);
      // Duty-cycle method: half the pulses pass
      bus(1, 8'h00, 32'h8); hot <= 1; wt(12);
      n = 0;
      n2 = 0;
      for (i = 0; i < 16; i = i + 1) begin
         wt(1);
         if (allow === 1'b0) n = n + 1;
         if (allow_e === 1'b0) n2 = n2 + 1;
      end
      chk("gated", 8, n);
      chk("gated_early", 8, n2);
      bus(1, 8'h08, 32'h55); wt_start; chk("perf_now", 1, n < 4);
      chk("target", 32'h55, {16'h0, pt});
      hot <= 0; wt(10);
      bus(0, 8'h14, 0); chk("hold", 1, rdv[0]);
      wt(HC * 2);
      bus(0, 8'h14, 0); chk("released", 0, rdv[0]);
      // Frequency/voltage method, as firmware would set it up
      bus(1, 8'h04, 32'h0001_1234);
      bus(1, 8'h00, 32'h0000_2008); hot <= 1; wt(8);
      chk("fv", 1, fv);
      chk("fv_early", 1, fv_e);
      chk("op_pt", 32'h1234, {16'h0, opp});
      bus(1, 8'h08, 32'haa); hot <= 0; wt_start;
      chk("perf_held", 1, n > HC);
      chk("target2", 32'haa, {16'h0, pt});
      // Catastrophic trip halts until the next reset
      cat <= 1; wt(2); cat <= 0; wt(10);
      chk("halt", 1, halt); chk("stopped", 0, allow);
      bus(0, 8'h14, 0); chk("stat_cat", 0, rdv);
      rst_n <= 0; wt(2); rst_n <= 1; wt(2);
      chk("halt_rst", 0, halt);
      final_report;
   end
endmodule
